// File: rtl/pcstk_pkg.sv
// Package for the program counter, return stack and indirect address block.
// Assumes one core clock and an execute stage that issues one operation per cycle.
package pcstk_pkg;
   localparam int unsigned PC_W        = 13;
   localparam int unsigned LOW_W       = 8;
   localparam int unsigned UPPER_W     = 5;
   localparam int unsigned DEPTH       = 8;
   localparam int unsigned JUMP_W      = 11;
   localparam int unsigned ADDR_W      = 9;
   localparam logic [12:0] PC_RESET    = 13'h0000;
   localparam logic [7:0]  PORT_ADDR   = 8'h00;
   localparam logic [7:0]  PORT_READ   = 8'h00;
   localparam int unsigned JMP_HI_LSB  = 3;
   localparam logic [12:0] PC_ONE      = 13'h0001;

   typedef enum logic [5:0] {
      OP_STEP  = 6'h01,
      OP_JUMP  = 6'h02,
      OP_CALL  = 6'h04,
      OP_IRQ   = 6'h08,
      OP_RET   = 6'h10,
      OP_WLOW  = 6'h20
   } pc_op_e;

   typedef struct packed {
      logic        valid;
      pc_op_e      op;
      logic [10:0] target;
      logic [7:0]  low_data;
      logic [12:0] vector;
   } pc_req_s;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  file_addr;
      logic [7:0]  wdata;
   } file_req_s;
endpackage : pcstk_pkg

// File: rtl/ret_stack_mem.sv
// Return address storage, registered read data.
// Assumes the owner supplies the write and read indices.
`timescale 1ns/1ps
`default_nettype none
module ret_stack_mem #(
   parameter int unsigned WIDTH = 13,
   parameter int unsigned DEPTH = 8,
   parameter int unsigned IDX_W = 3
) (
   // Clock and reset.
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   // Write side.
   input  wire logic             wr_en,
   input  wire logic [IDX_W-1:0] wr_idx,
   input  wire logic [WIDTH-1:0] wr_data,
   // Read side.
   input  wire logic [IDX_W-1:0] rd_idx,
   output logic      [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem_q [DEPTH];

   initial begin
      if (DEPTH != (1 << IDX_W)) $error("ret_stack_mem depth must be two to the index width.");
   end

   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem_q[wr_idx] <= wr_data;
      end
   end

   // Read data is registered so the pop path is one cycle.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem_q[rd_idx];
      end
   end
endmodule : ret_stack_mem
`default_nettype wire

// File: rtl/pc_stack_indirect_addressing.sv
// Program counter, circular return stack and indirect data address former.
// Assumes the execute stage holds each request valid for one cycle and, after a
// return, waits until pc_busy_q falls before the next program counter request.
`timescale 1ns/1ps
`default_nettype none
module pc_stack_indirect_addressing
   import pcstk_pkg::*;
#(
   parameter int unsigned STACK_DEPTH = DEPTH
) (
   // Clock and reset.
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   // Program counter requests from execute.
   input  wire pc_req_s           pc_req,
   input  wire logic              latch_we,
   input  wire logic [7:0]        latch_wdata,
   // Indirect access from execute; file_rdata comes from data memory.
   input  wire file_req_s         file_req,
   input  wire logic              indirect_bank_bit,
   input  wire logic [7:0]        indirect_pointer_reg,
   input  wire logic [7:0]        file_rdata,
   // Program counter state.
   output logic      [12:0]       pc_q,
   output logic      [7:0]        pc_low_byte_reg,
   output logic      [7:0]        pc_high_bits_latch,
   output logic                   pc_busy_q,
   // Data memory side.
   output logic                   data_valid_q,
   output logic                   data_write_q,
   output logic      [8:0]        data_addr_q,
   output logic      [7:0]        data_wdata_q,
   output logic      [7:0]        port_rdata_q,
   output logic                   port_self_q
);
   localparam int unsigned IDX_W = $clog2(STACK_DEPTH);

   initial begin
      if (STACK_DEPTH != DEPTH) $error("Stack depth is fixed at eight entries.");
   end

   typedef struct packed {
      logic [12:0]      pc;
      logic [7:0]       latch;
      logic [IDX_W-1:0] sp;
      logic             pop_wait;
      logic             dvalid;
      logic             dwrite;
      logic [8:0]       daddr;
      logic [7:0]       dwdata;
      logic [7:0]       prdata;
      logic             pself;
   } state_s;

   state_s           st_q;
   state_s           st_d;
   logic             push_en;
   logic [IDX_W-1:0] rd_idx;
   logic [12:0]      pop_data;
   logic             is_port;
   logic             self_sel;

   // The pointer is never a port or field visible to software.
   // Overflow and underflow are never flagged; no such output exists.
   // A call refused while a pop is pending must not touch the stack either.
   assign push_en = pc_req.valid && !st_q.pop_wait &&
                    (pc_req.op == OP_CALL || pc_req.op == OP_IRQ);
   assign rd_idx  = st_q.sp - IDX_W'(1);
   assign is_port = file_req.valid && (file_req.file_addr == PORT_ADDR);
   assign self_sel = indirect_pointer_reg == PORT_ADDR;

   ret_stack_mem #(
      .WIDTH (PC_W),
      .DEPTH (DEPTH),
      .IDX_W (IDX_W)
   ) u_mem (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .wr_en   (push_en),
      .wr_idx  (st_q.sp),
      .wr_data (st_q.pc),
      .rd_idx  (rd_idx),
      .rd_data (pop_data)
   );

   always_comb begin
      st_d = st_q;
      st_d.dvalid = 1'b0;
      st_d.dwrite = 1'b0;
      if (st_q.pop_wait) begin
         st_d.pc       = pop_data;
         st_d.pop_wait = 1'b0;
      end else if (pc_req.valid) begin
         case (pc_req.op)
            OP_STEP: st_d.pc = st_q.pc + PC_ONE;
            OP_JUMP, OP_CALL: begin
               st_d.pc = {st_q.latch[4:JMP_HI_LSB], pc_req.target};
            end
            OP_IRQ: st_d.pc = pc_req.vector;
            OP_WLOW: begin
               // No carry reaches the latch; software adjusts it itself.
               st_d.pc = {st_q.latch[UPPER_W-1:0], pc_req.low_data};
            end
            OP_RET: begin
               st_d.sp       = st_q.sp - IDX_W'(1);
               st_d.pop_wait = 1'b1;
            end
            default: st_d.pc = st_q.pc;
         endcase
         if (push_en) begin
            st_d.sp = st_q.sp + IDX_W'(1);
         end
      end
      // Only software writes move the latch, never the stack.
      if (latch_we) begin
         st_d.latch = latch_wdata;
      end
      if (file_req.valid) begin
         st_d.dvalid = 1'b1;
         st_d.dwrite = file_req.write;
         st_d.dwdata = file_req.wdata;
         st_d.pself  = 1'b0;
         if (is_port) begin
            st_d.daddr = {indirect_bank_bit, indirect_pointer_reg};
            if (self_sel) begin
               st_d.pself  = 1'b1;
               st_d.dvalid = 1'b0;
               st_d.dwrite = 1'b0;
            end
         end else begin
            st_d.daddr = {indirect_bank_bit, file_req.file_addr};
         end
      end
      // Self-selected reads see zero; others pass the memory data through.
      st_d.prdata = st_q.pself ? PORT_READ : file_rdata;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign pc_q               = st_q.pc;
   assign pc_low_byte_reg    = st_q.pc[7:0];
   assign pc_high_bits_latch = st_q.latch;
   assign pc_busy_q          = st_q.pop_wait;
   assign data_valid_q       = st_q.dvalid;
   assign data_write_q       = st_q.dwrite;
   assign data_addr_q        = st_q.daddr;
   assign data_wdata_q       = st_q.dwdata;
   assign port_rdata_q       = st_q.prdata;
   assign port_self_q        = st_q.pself;

   a_reset_clear: assert property (@(posedge clk_sys) $rose(rst_n) |-> pc_q == PC_RESET)
      else $error("Counter not zero after reset.");

   a_low_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
      pc_req.valid && pc_req.op == OP_WLOW && !pc_busy_q |=>
      pc_q == {$past(pc_high_bits_latch[4:0]), $past(pc_req.low_data)})
      else $error("Low write did not load all 13 bits.");

   a_jump_upper: assert property (@(posedge clk_sys) disable iff (!rst_n)
      pc_req.valid && (pc_req.op == OP_JUMP || pc_req.op == OP_CALL) && !pc_busy_q |=>
      pc_q[12:11] == $past(pc_high_bits_latch[4:3]) && pc_q[10:0] == $past(pc_req.target))
      else $error("Jump upper bits wrong.");

   a_call_return: assert property (@(posedge clk_sys) disable iff (!rst_n)
      pc_req.valid && pc_req.op == OP_CALL && !pc_busy_q ##1
      pc_req.valid && pc_req.op == OP_RET && !pc_busy_q |-> ##2 pc_q == $past(pc_q, 3))
      else $error("Return did not restore pushed counter.");

   a_pop_busy: assert property (@(posedge clk_sys) disable iff (!rst_n)
      pc_req.valid && pc_req.op == OP_RET && !pc_busy_q |=> pc_busy_q ##1 !pc_busy_q)
      else $error("Pop wait not one cycle.");

   a_latch_stable: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !latch_we |=> $stable(pc_high_bits_latch))
      else $error("Latch changed without write.");

   a_self_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
      port_self_q |=> port_rdata_q == PORT_READ)
      else $error("Self-selected read not zero.");

   a_self_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
      port_self_q |-> !data_valid_q && !data_write_q)
      else $error("Self-selected write reached memory.");

   a_wdata_pass: assert property (@(posedge clk_sys) disable iff (!rst_n)
      file_req.valid |=> data_wdata_q == $past(file_req.wdata))
      else $error("Write data not passed to memory.");

   a_ind_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
      is_port && !self_sel |=> data_valid_q &&
      data_addr_q == {$past(indirect_bank_bit), $past(indirect_pointer_reg)})
      else $error("Indirect address wrong.");
endmodule : pc_stack_indirect_addressing
`default_nettype wire

// File: bench/data_ram_model.sv
// Data memory model standing behind the block's data side.
// Assumes reads are combinational from the registered address, writes land on the clock.
`timescale 1ns/1ps
`default_nettype none
module data_ram_model (
   // Clock.
   input  wire logic       clk_sys,
   // Access from the block.
   input  wire logic       data_valid_q,
   input  wire logic       data_write_q,
   input  wire logic [8:0] data_addr_q,
   input  wire logic [7:0] data_wdata_q,
   // Read data back.
   output logic      [7:0] file_rdata
);
   logic [7:0] mem [512];
   initial begin
      foreach (mem[i]) mem[i] = 8'h00;
   end
   // Outside an access the bus shows the inverse, so stale data cannot pass for a match.
   assign file_rdata = data_valid_q ? mem[data_addr_q] : ~mem[data_addr_q];
   always @(posedge clk_sys) begin
      if (data_valid_q && data_write_q) mem[data_addr_q] <= data_wdata_q;
   end
endmodule : data_ram_model
`default_nettype wire

// File: bench/pc_stack_indirect_addressing_tb.sv
// Self-checking bench for the program counter, return stack and indirect addresses.
// Assumes the data memory model answers the block's data side.
`timescale 1ns/1ps
`default_nettype none
module pc_stack_indirect_addressing_tb;
   import pcstk_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   pc_req_s     pc_req = '0;
   logic        latch_we = 1'b0;
   logic [7:0]  latch_wdata = 8'h00;
   file_req_s   file_req = '0;
   logic        indirect_bank_bit = 1'b1;
   logic [7:0]  indirect_pointer_reg = 8'h00;
   wire logic [7:0] file_rdata;
   logic [12:0] pc_q;
   logic [7:0]  pc_low_byte_reg, pc_high_bits_latch, data_wdata_q, port_rdata_q;
   logic        pc_busy_q, data_valid_q, data_write_q, port_self_q;
   logic [8:0]  data_addr_q;
   logic [12:0] stk [8];
   logic [12:0] epc = 13'h0000;
   logic [2:0]  sp = 3'h0;
   logic [7:0]  lat = 8'h00;
   int          n_errors = 0;
   int          num_checks = 0;

   always #2.5 clk_sys = ~clk_sys;

   pc_stack_indirect_addressing DUT (.clk_sys, .rst_n, .pc_req, .latch_we, .latch_wdata,
      .file_req, .indirect_bank_bit, .indirect_pointer_reg, .file_rdata, .pc_q,
      .pc_low_byte_reg, .pc_high_bits_latch, .pc_busy_q, .data_valid_q, .data_write_q,
      .data_addr_q, .data_wdata_q, .port_rdata_q, .port_self_q);
   data_ram_model ram (.clk_sys, .data_valid_q, .data_write_q, .data_addr_q,
      .data_wdata_q, .file_rdata);

   task automatic test_done;
      if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : test_done

   task automatic chk(input logic [12:0] got, input logic [12:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic pc_op(input pc_op_e op, input logic [10:0] t, input logic [7:0] l,
                        input logic [12:0] v);
      @(posedge clk_sys);
      pc_req <= '{1'b1, op, t, l, v};
      @(posedge clk_sys);
      pc_req.valid <= 1'b0;
      #1;
   endtask : pc_op

   task automatic set_latch(input logic [7:0] d);
      @(posedge clk_sys);
      latch_we <= 1'b1;
      latch_wdata <= d;
      lat = d;
      @(posedge clk_sys);
      latch_we <= 1'b0;
   endtask : set_latch

   task automatic push(input pc_op_e op, input logic [10:0] t);
      stk[sp] = epc;
      sp++;
      epc = (op == OP_IRQ) ? 13'h0004 : {lat[4:3], t};
      pc_op(op, t, 8'h00, 13'h0004);
      chk(pc_q, epc);
   endtask : push

   task automatic pop;
      sp--;
      epc = stk[sp];
      pc_op(OP_RET, 11'h000, 8'h00, 13'h0000);
      chk({12'h000, pc_busy_q}, 13'h0001);
      @(posedge clk_sys);
      #1;
      chk(pc_q, epc);
      chk({5'h00, pc_high_bits_latch}, {5'h00, lat});
   endtask : pop

   // Accesses always name the port; ex packs valid, write, self and address.
   task automatic facc(input logic w, input logic [7:0] p, input logic [7:0] d,
                       input logic [12:0] ex, input logic [7:0] er);
      @(posedge clk_sys);
      indirect_pointer_reg <= p;
      file_req <= '{1'b1, w, PORT_ADDR, d};
      @(posedge clk_sys);
      file_req.valid <= 1'b0;
      #1;
      chk({1'b0, data_valid_q, data_write_q, port_self_q, data_addr_q}, ex);
      @(posedge clk_sys);
      #1;
      if (!w) chk({5'h00, port_rdata_q}, {5'h00, er});
   endtask : facc

   initial begin
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      #1;
      chk(pc_q, 13'h0000);
      set_latch(8'h1a);
      pc_op(OP_WLOW, 11'h000, 8'h34, 13'h0000);
      chk(pc_q, 13'h1a34);
      chk({5'h00, pc_low_byte_reg}, 13'h0034);
      pc_op(OP_WLOW, 11'h000, 8'hff, 13'h0000);
      pc_op(OP_STEP, 11'h000, 8'h00, 13'h0000);
      chk({5'h00, pc_high_bits_latch}, 13'h001a);
      pc_op(OP_JUMP, 11'h5a5, 8'h00, 13'h0000);
      chk(pc_q, 13'h1da5);
      epc = 13'h1da5;
      // Nine pushes so the last one overwrites the oldest entry.
      for (int i = 0; i < 9; i++) push(i == 4 ? OP_IRQ : OP_CALL, 11'h100 + 11'(i));
      for (int i = 0; i < 9; i++) pop();
      facc(1'b1, 8'h25, 8'h77, {4'h6, 9'h125}, 8'h00);
      facc(1'b0, 8'h25, 8'h00, {4'h4, 9'h125}, 8'h77);
      facc(1'b1, 8'h00, 8'h55, {4'h1, 9'h100}, 8'h00);
      facc(1'b0, 8'h00, 8'h00, {4'h1, 9'h100}, 8'h00);
      facc(1'b0, 8'h25, 8'h00, {4'h4, 9'h125}, 8'h77);
      @(posedge clk_sys);
      rst_n <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk(pc_q, 13'h0000);
      test_done();
   end

   // The sequence needs well under a thousand cycles; this bound is generous.
   initial begin
      #20000;
      n_errors++;
      test_done();
   end
endmodule : pc_stack_indirect_addressing_tb
`default_nettype wire
